// File: rtl/aatl_top.sv
/*
 Alarm threshold logic of an 18-bit converter: input and supply alarms,
 active and tripped flags, shared alarm pin, frame snapshot and appended bits.
 Registers sit behind an AXI4-Lite slave. Assumes conversion results arrive
 as a one-cycle strobe on aclk; comparator outputs and the chip-select pin
 are asynchronous and are synchronised here.
*/
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
`include "aatl_defines.svh"

module aatl_top
   import aatl_pkg::*;
(
   input  wire logic                     aclk,
   input  wire logic                     aresetn,
   input  wire logic [`AATL_ADDR_W-1:0]  s_axi_awaddr,
   input  wire logic                     s_axi_awvalid,
   output logic                          s_axi_awready,
   input  wire logic [31:0]              s_axi_wdata,
   input  wire logic [3:0]               s_axi_wstrb,
   input  wire logic                     s_axi_wvalid,
   output logic                          s_axi_wready,
   output logic [1:0]                    s_axi_bresp,
   output logic                          s_axi_bvalid,
   input  wire logic                     s_axi_bready,
   input  wire logic [`AATL_ADDR_W-1:0]  s_axi_araddr,
   input  wire logic                     s_axi_arvalid,
   output logic                          s_axi_arready,
   output logic [31:0]                   s_axi_rdata,
   output logic [1:0]                    s_axi_rresp,
   output logic                          s_axi_rvalid,
   input  wire logic                     s_axi_rready,
   input  wire logic                     conv_done,
   input  wire aatl_code_t               conv_code,
   input  wire logic                     supply_over_cmp,
   input  wire logic                     supply_under_cmp,
   input  wire logic                     convert_chip_select_n,
   input  wire logic                     serial_flag_read,
   input  wire logic                     alt_function_data,
   output logic                          shared_alarm_output_pin,
   output aatl_code_t                    conversion_data,
   output logic [7:0]                    frame_flags,
   output logic [3:0]                    append_bits,
   output logic [1:0]                    append_select
);

   // Software-visible configuration
   logic [1:0]  second_output_function_select_r;
   logic        input_alarm_disable_r;
   logic        supply_alarm_disable_r;
   aatl_code_t  high_threshold_r;
   aatl_code_t  low_threshold_r;
   aatl_hyst_t  hyst_r;
   logic [1:0]  format_select_r;

   // Alarm state, flags and last conversion code
   logic        in_hi_state_r;
   logic        in_lo_state_r;
   logic        in_hi_state_nxt;
   logic        in_lo_state_nxt;
   logic [3:0]  active_r;
   logic [3:0]  tripped_r;
   logic [3:0]  active_nxt;
   aatl_code_t  last_code_r;

   // Synchronisers, chip-select edge and frame state
   logic [1:0]  sup_over_sync_r;
   logic [1:0]  sup_under_sync_r;
   logic [1:0]  cs_sync_r;
   logic        cs_prev_r;
   aatl_frame_t frame_r;

   // Bus slave state
   logic                    aw_held_r;
   logic                    w_held_r;
   logic [`AATL_ADDR_W-1:0] aw_addr_r;
   logic [31:0]             w_data_r;
   logic [3:0]              w_strb_r;
   logic                    do_write;
   logic                    wr_hit;
   logic                    rd_take;
   logic                    rd_hit;
   logic [31:0]             rd_word;
   logic                    flags_read;

   logic alarm_on;
   logic in_enabled;
   logic sup_enabled;
   logic alarm_level;

   // R7 alarms on with pin select
   assign alarm_on    = (second_output_function_select_r == `AATL_SEL_ALARM);
   assign in_enabled  = alarm_on & ~input_alarm_disable_r;
   assign sup_enabled = alarm_on & ~supply_alarm_disable_r;

   // Asynchronous levels pass two flip-flops first
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sup_over_sync_r  <= 2'b00;
         sup_under_sync_r <= 2'b00;
         cs_sync_r        <= 2'b11;
      end else begin
         sup_over_sync_r  <= {sup_over_sync_r[0], supply_over_cmp};
         sup_under_sync_r <= {sup_under_sync_r[0], supply_under_cmp};
         cs_sync_r        <= {cs_sync_r[0], convert_chip_select_n};
      end
   end

   aatl_hyst_cmp u_cmp_high (
      .low_side  (1'b0),
      .code      (conv_code),
      .thr       (high_threshold_r),
      .hyst      (hyst_r),
      .state     (in_hi_state_r),
      .state_nxt (in_hi_state_nxt)
   );

   aatl_hyst_cmp u_cmp_low (
      .low_side  (1'b1),
      .code      (conv_code),
      .thr       (low_threshold_r),
      .hyst      (hyst_r),
      .state     (in_lo_state_r),
      .state_nxt (in_lo_state_nxt)
   );

   // Flag order: input high, input low, supply high, supply low
   always_comb begin
      // R5 both input comparisons
      active_nxt[0] = in_enabled & in_hi_state_nxt;
      active_nxt[1] = in_enabled & in_lo_state_nxt;
      // R6 fixed supply trip points
      active_nxt[2] = sup_enabled & sup_over_sync_r[1];
      active_nxt[3] = sup_enabled & sup_under_sync_r[1];
   end

   // Hysteresis state only moves on a conversion result
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         in_hi_state_r <= 1'b0;
         in_lo_state_r <= 1'b0;
      end else if (conv_done) begin
         in_hi_state_r <= in_enabled & in_hi_state_nxt;
         in_lo_state_r <= in_enabled & in_lo_state_nxt;
      end
   end

   // R9 rebuilt each conversion
   // R11 updates at conversion end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         active_r <= 4'h0;
      end else if (conv_done) begin
         active_r <= active_nxt;
      end
   end

   // R10 cleared by flag read
   // R8 both flags set together; a new trigger beats a same-cycle read
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tripped_r <= 4'h0;
      end else begin
         tripped_r <= (tripped_r & ~{4{flags_read | serial_flag_read}})
                      | (active_nxt & {4{conv_done}});
      end
   end

   // R1 straight binary passthrough
   // R2 full 18-bit code
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         last_code_r <= '0;
      end else if (conv_done) begin
         last_code_r <= conv_code;
      end
   end

   assign conversion_data = last_code_r;

   // R13 any active condition
   assign alarm_level = |active_r;

   // R4 pin carries alarm on 01b
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         shared_alarm_output_pin <= 1'b0;
      end else begin
         shared_alarm_output_pin <= alarm_on ? alarm_level : alt_function_data;
      end
   end

   // R12 snapshot when frame opens
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cs_prev_r   <= 1'b1;
         frame_r     <= AATL_FR_IDLE;
         frame_flags <= 8'h00;
      end else begin
         cs_prev_r <= cs_sync_r[1];
         case (frame_r)
            AATL_FR_IDLE: begin
               if (cs_prev_r && !cs_sync_r[1]) begin
                  frame_r     <= AATL_FR_OPEN;
                  frame_flags <= {tripped_r[3], active_r[3], tripped_r[2], active_r[2],
                                  tripped_r[1], active_r[1], tripped_r[0], active_r[0]};
               end
            end
            AATL_FR_OPEN: begin
               if (cs_sync_r[1]) begin
                  frame_r <= AATL_FR_IDLE;
               end
            end
            default: begin
               frame_r <= AATL_FR_IDLE;
            end
         endcase
      end
   end

   // R14 selected flags appended
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         append_bits   <= 4'h0;
         append_select <= 2'b00;
      end else begin
         append_select <= format_select_r;
         append_bits[1:0] <= format_select_r[`AATL_APP_IN_BIT]
                             ? {active_r[1] | active_r[0], tripped_r[1] | tripped_r[0]} : 2'b00;
         append_bits[3:2] <= format_select_r[`AATL_APP_SUP_BIT]
                             ? {active_r[3] | active_r[2], tripped_r[3] | tripped_r[2]} : 2'b00;
      end
   end

   // Write channel: address and data are taken in either order
   assign s_axi_awready = ~aw_held_r;
   assign s_axi_wready  = ~w_held_r;
   assign do_write      = aw_held_r & w_held_r & ~s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         aw_addr_r <= '0;
      end else if (s_axi_awvalid && !aw_held_r) begin
         aw_held_r <= 1'b1;
         aw_addr_r <= s_axi_awaddr;
      end else if (do_write) begin
         aw_held_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_r <= 1'b0;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
      end else if (s_axi_wvalid && !w_held_r) begin
         w_held_r <= 1'b1;
         w_data_r <= s_axi_wdata;
         w_strb_r <= s_axi_wstrb;
      end else if (do_write) begin
         w_held_r <= 1'b0;
      end
   end

   always_comb begin
      case (aw_addr_r)
         `AATL_OFF_OUT_CTL, `AATL_OFF_PWR_CTL, `AATL_OFF_HIGH_TH, `AATL_OFF_LOW_TH,
         `AATL_OFF_HYST, `AATL_OFF_FMT_CTL: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   // R19 separate thresholds, shared hysteresis
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         second_output_function_select_r <= `AATL_RST_SEL;
         input_alarm_disable_r           <= 1'b0;
         supply_alarm_disable_r          <= 1'b0;
         high_threshold_r                <= `AATL_RST_HIGH_TH;
         low_threshold_r                 <= `AATL_RST_LOW_TH;
         hyst_r                          <= `AATL_RST_HYST;
         format_select_r                 <= 2'b00;
      end else if (do_write && w_strb_r[0]) begin
         case (aw_addr_r)
            `AATL_OFF_OUT_CTL: second_output_function_select_r <= w_data_r[`AATL_SEL_LSB+:2];
            `AATL_OFF_PWR_CTL: begin
               input_alarm_disable_r  <= w_data_r[`AATL_IN_DIS_BIT];
               supply_alarm_disable_r <= w_data_r[`AATL_SUP_DIS_BIT];
            end
            `AATL_OFF_HIGH_TH: high_threshold_r[7:0] <= w_data_r[7:0];
            `AATL_OFF_LOW_TH:  low_threshold_r[7:0]  <= w_data_r[7:0];
            `AATL_OFF_HYST:    hyst_r                <= w_data_r[7:0];
            `AATL_OFF_FMT_CTL: format_select_r       <= w_data_r[1:0];
            default: begin
            end
         endcase
      end
      if (aresetn && do_write && w_strb_r[1]) begin
         if (aw_addr_r == `AATL_OFF_HIGH_TH) begin
            high_threshold_r[15:8] <= w_data_r[15:8];
         end
         if (aw_addr_r == `AATL_OFF_LOW_TH) begin
            low_threshold_r[15:8] <= w_data_r[15:8];
         end
      end
      if (aresetn && do_write && w_strb_r[2]) begin
         if (aw_addr_r == `AATL_OFF_HIGH_TH) begin
            high_threshold_r[17:16] <= w_data_r[17:16];
         end
         if (aw_addr_r == `AATL_OFF_LOW_TH) begin
            low_threshold_r[17:16] <= w_data_r[17:16];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `AATL_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_hit ? `AATL_RESP_OKAY : `AATL_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Read channel: one read in flight, answer one cycle after address
   assign s_axi_arready = ~s_axi_rvalid;
   assign rd_take       = s_axi_arvalid & ~s_axi_rvalid;
   // R20 host read clears trips
   assign flags_read    = rd_take & (s_axi_araddr == `AATL_OFF_FLAGS);

   always_comb begin
      rd_hit  = 1'b1;
      rd_word = 32'h0000_0000;
      case (s_axi_araddr)
         `AATL_OFF_OUT_CTL:   rd_word[1:0] = second_output_function_select_r;
         `AATL_OFF_PWR_CTL:   rd_word[1:0] = {supply_alarm_disable_r, input_alarm_disable_r};
         `AATL_OFF_HIGH_TH:   rd_word[17:0] = high_threshold_r;
         `AATL_OFF_LOW_TH:    rd_word[17:0] = low_threshold_r;
         `AATL_OFF_HYST:      rd_word[7:0] = hyst_r;
         `AATL_OFF_FLAGS:     rd_word[8:0] = {alarm_level,
                                              tripped_r[3], active_r[3], tripped_r[2], active_r[2],
                                              tripped_r[1], active_r[1], tripped_r[0], active_r[0]};
         `AATL_OFF_FMT_CTL:   rd_word[1:0] = format_select_r;
         `AATL_OFF_LAST_CODE: rd_word[17:0] = last_code_r;
         default:             rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `AATL_RESP_OKAY;
      end else if (rd_take) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_word;
         s_axi_rresp  <= rd_hit ? `AATL_RESP_OKAY : `AATL_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule

// File: rtl/aatl_defines.svh
/*
 Offsets, field positions, reset values and fixed figures of the alarm threshold block.
 Assumes inclusion by bare name from the package and the design modules.
*/
// How it works
// R1 - Conversion codes are passed on as unsigned straight binary for every range.
// R2 - Codes are 18 bits; one step is the span over two to the eighteenth.
// R3 - Span is positive full scale minus negative full scale, e.g. 24.576 V, 12.288 V.
// R4 - Shared pin carries the active-high alarm only when its select field is 01b.
// R5 - Each conversion is compared against a high and a low threshold.
// R6 - Supply alarm rises when the comparator reports above 5.3 V or below 4.7 V.
// R7 - With alarms on, input and supply alarms are enabled unless their disable bit is set.
// R8 - Each alarm source has an active and a tripped flag, both set on trigger.
// R9 - Active flag is rebuilt at each conversion end from the present condition.
// R10 - Tripped flag holds until the alarm flag register is read.
// R11 - All flags change only at the end of a conversion; tripped flags here also clear on a flag read in any cycle.
// R12 - Flags can be read in any frame opened by the convert/chip-select line low.
// R13 - Alarm pin is high while any supply or input over/under condition stands.
// R14 - Selected flags can be appended to the serial conversion output stream.
// R15 - Input high alarm sets when the code is strictly above the high threshold.
// R16 - Input high alarm clears when code is at most threshold minus hysteresis minus one.
// R17 - Input low alarm sets when the code is strictly below the low threshold.
// R18 - Input low alarm clears when code is at least threshold plus hysteresis plus one.
// R19 - High and low thresholds are separate registers; one hysteresis value serves both.
// R20 - Host reads the flag register after the alarm pin rises to find the cause.
// R21 - Threshold arithmetic is unsigned on 18-bit codes and never wraps.
`ifndef AATL_DEFINES_SVH
`define AATL_DEFINES_SVH

`define AATL_CODE_W        18
`define AATL_HYST_W        8
`define AATL_ADDR_W        8

`define AATL_OFF_OUT_CTL   8'h00
`define AATL_OFF_PWR_CTL   8'h04
`define AATL_OFF_HIGH_TH   8'h08
`define AATL_OFF_LOW_TH    8'h0C
`define AATL_OFF_HYST      8'h10
`define AATL_OFF_FLAGS     8'h14
`define AATL_OFF_FMT_CTL   8'h18
`define AATL_OFF_LAST_CODE 8'h1C

// Output control: second output function select field
`define AATL_SEL_LSB       0
`define AATL_SEL_ALARM     2'b01
// Power control: disable bits
`define AATL_IN_DIS_BIT    0
`define AATL_SUP_DIS_BIT   1
// Format control: append selections
`define AATL_APP_IN_BIT    0
`define AATL_APP_SUP_BIT   1

`define AATL_RST_SEL       2'b00
`define AATL_RST_HIGH_TH   18'h3_FFFF
`define AATL_RST_LOW_TH    18'h0_0000
`define AATL_RST_HYST      8'h00

`define AATL_RESP_OKAY     2'b00
`define AATL_RESP_SLVERR   2'b10

// R6 supply and R3 span figures; the code width sets the step and the comparators set the trip points, so these stay reference only
`define AATL_SUP_HI_MV     5300
`define AATL_SUP_LO_MV     4700
`define AATL_SPAN_BIP_MV   24576
`define AATL_SPAN_UNI_MV   12288

`endif

// File: rtl/aatl_pkg.sv
/*
 Types shared by the alarm threshold block.
 Assumes the defines header is on the include path.
*/
`include "aatl_defines.svh"

package aatl_pkg;
   typedef logic [`AATL_CODE_W-1:0] aatl_code_t;
   typedef logic [`AATL_HYST_W-1:0] aatl_hyst_t;
   typedef enum logic [1:0] {
      AATL_FR_IDLE = 2'b01,
      AATL_FR_OPEN = 2'b10
   } aatl_frame_t;
endpackage

// File: rtl/aatl_hyst_cmp.sv
/*
 One threshold comparator with hysteresis; gives the next alarm state.
 Assumes the caller samples the result only at the end of a conversion.
*/
`timescale 1ns/100ps
`include "aatl_defines.svh"

module aatl_hyst_cmp
   import aatl_pkg::*;
(
   input  wire logic       low_side,
   input  wire aatl_code_t code,
   input  wire aatl_code_t thr,
   input  wire aatl_hyst_t hyst,
   input  wire logic       state,
   output logic            state_nxt
);
   // One extra bit keeps threshold plus hysteresis from wrapping
   logic [`AATL_CODE_W:0] band;

   always_comb begin
      band      = {1'b0, thr};
      state_nxt = state;
      if (low_side) begin
         // R17 below threshold
         if (code < thr) begin
            state_nxt = 1'b1;
         end
         // R18 clear above band
         // R21 widened sum
         else if ({1'b0, code} >= band + {{(`AATL_CODE_W-`AATL_HYST_W){1'b0}}, hyst} + 1'b1) begin
            state_nxt = 1'b0;
         end
      end else begin
         // R15 above threshold
         if (code > thr) begin
            state_nxt = 1'b1;
         end
         // R16 clear below band
         // R21 no underflow
         else if ({1'b0, code} + {{(`AATL_CODE_W-`AATL_HYST_W){1'b0}}, hyst} + 1'b1 <= band) begin
            state_nxt = 1'b0;
         end
      end
   end
endmodule

// File: testbench/aatl_monitor.sv
/*
 Port checker for the alarm threshold block.
 Assumes it is bound onto aatl_top and sees only its ports.
*/
`timescale 1ns/100ps
module aatl_monitor
   import aatl_pkg::*;
(
   input logic       aclk,
   input logic       aresetn,
   input logic       s_axi_bvalid,
   input logic       s_axi_bready,
   input logic       s_axi_arvalid,
   input logic       s_axi_arready,
   input logic       s_axi_rvalid,
   input logic       s_axi_rready,
   input logic [31:0] s_axi_rdata,
   input logic       conv_done,
   input aatl_code_t conv_code,
   input aatl_code_t conversion_data,
   input logic       convert_chip_select_n,
   input logic       serial_flag_read,
   input logic [7:0] frame_flags,
   input logic [3:0] append_bits,
   input logic [1:0] append_select
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped before bready");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data moved before rready");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered in one cycle");
   code_capture_a: assert property (conv_done |=> conversion_data == $past(conv_code))
      else $error("conversion code not passed on unchanged");
   code_hold_a: assert property (!conv_done |=> $stable(conversion_data))
      else $error("conversion data moved without a conversion end");
   frame_snap_a: assert property ($changed(frame_flags) |-> !$past(convert_chip_select_n, 2))
      else $error("frame flags changed outside a frame");
   append_off_a: assert property (!append_select[0] |-> append_bits[1:0] == 2'h0)
      else $error("input flags appended while not selected");
   serial_clear_a: assert property (serial_flag_read && !conv_done && append_select[1]
                                    |-> ##[1:3] !append_bits[2])
      else $error("supply tripped flag kept after serial read");

   cover property (conv_done);
   cover property ($changed(frame_flags));
   cover property (s_axi_rvalid && s_axi_rready);
endmodule

// File: testbench/aatl_host_model.sv
/*
 Host controller model: opens frames on the chip-select line and reads flags
 over the serial path once the alarm pin rises. Assumes the bench calls its tasks.
*/
`timescale 1ns/100ps
module aatl_host_model (
   input  logic aclk,
   input  logic alarm_pin,
   output logic convert_chip_select_n,
   output logic serial_flag_read
);
   initial begin
      convert_chip_select_n = 1'h1;
      serial_flag_read = 1'h0;
   end

   task automatic open_frame(input int len);
      @(posedge aclk);
      convert_chip_select_n <= 1'h0;
      repeat (len) @(posedge aclk);
      convert_chip_select_n <= 1'h1;
   endtask

   task automatic serve_alarm(output logic got);
      got = 1'h0;
      for (int i = 0; i < 20 && !got; i++) begin
         @(posedge aclk);
         got = alarm_pin;
      end
      if (got) begin
         serial_flag_read <= 1'h1;
         @(posedge aclk);
         serial_flag_read <= 1'h0;
      end
   endtask
endmodule

// File: testbench/adc_alarm_threshold_logic_test.sv
/*
 Self-checking bench for the alarm threshold block.
 Assumes the design files, checker and host model are compiled first.
*/
`timescale 1ns/100ps
module adc_alarm_threshold_logic_test;
   import aatl_pkg::*;
   logic        aclk = 1'h0;
   logic        aresetn = 1'h0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0]  wstrb = 4'hF;
   logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic        conv_done = 1'h0, sup_over = 1'h0, sup_under = 1'h0, alt_data = 1'h1;
   aatl_code_t  conv_code = 18'h0_0000;
   logic        awready, wready, bvalid, arready, rvalid, pin, cs_n, flag_rd, got;
   logic [1:0]  bresp, rresp, app_sel;
   logic [31:0] rdata;
   aatl_code_t  conv_data;
   logic [7:0]  frm;
   logic [3:0]  app_bits;
   int          error_cnt = 0, samples_checked = 0;

   always #25 aclk = ~aclk;

   aatl_top dut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .conv_done(conv_done),
      .conv_code(conv_code), .supply_over_cmp(sup_over), .supply_under_cmp(sup_under),
      .convert_chip_select_n(cs_n), .serial_flag_read(flag_rd), .alt_function_data(alt_data),
      .shared_alarm_output_pin(pin), .conversion_data(conv_data), .frame_flags(frm),
      .append_bits(app_bits), .append_select(app_sel));

   aatl_host_model host (.aclk(aclk), .alarm_pin(pin), .convert_chip_select_n(cs_n), .serial_flag_read(flag_rd));

   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask

   task tally_and_finish;
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task tmo;
      chk("handshake timeout", 32'h0000_0001, 32'h0000_0000);
      tally_and_finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      bit done;
      done = 0;
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'h1;
      wdata <= d;
      wvalid <= 1'h1;
      bready <= 1'h1;
      for (int n = 0; n < 40 && !done; n++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'h0;
         if (wvalid && wready) wvalid <= 1'h0;
         if (bvalid) begin
            bready <= 1'h0;
            done = 1;
            chk("bresp", 32'(bresp), 32'(er));
         end
      end
      if (!done) tmo();
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      bit done;
      done = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      for (int n = 0; n < 40 && !done; n++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'h0;
         if (rvalid) begin
            rready <= 1'h0;
            done = 1;
            chk("rdata", rdata, e);
            chk("rresp", 32'(rresp), 32'(er));
         end
      end
      if (!done) tmo();
   endtask

   task automatic conv(input aatl_code_t c);
      @(posedge aclk);
      conv_done <= 1'h1;
      conv_code <= c;
      @(posedge aclk);
      conv_done <= 1'h0;
      repeat (3) @(posedge aclk);
      chk("conversion_data", 32'(conv_data), 32'(c));
   endtask

   task t_reset;
      rd(8'h08, 32'h0003_FFFF, 2'h0);
      rd(8'h0C, 32'h0000_0000, 2'h0);
      rd(8'h10, 32'h0000_0000, 2'h0);
      rd(8'h20, 32'h0000_0000, 2'h2);
      wr(8'h1C, 32'h0000_0001, 2'h2);
      wr(8'h00, 32'h0000_0001, 2'h0);
      conv(18'h3_FFFF);
      conv(18'h0_0000);
      rd(8'h14, 32'h0000_0000, 2'h0);
      chk("pin", 32'(pin), 32'h0000_0000);
   endtask

   task t_high;
      wr(8'h08, 32'h0002_0000, 2'h0);
      wr(8'h10, 32'h0000_0004, 2'h0);
      conv(18'h2_0000);
      rd(8'h14, 32'h0000_0000, 2'h0);
      conv(18'h2_0001);
      chk("pin", 32'(pin), 32'h0000_0001);
      conv(18'h1_FFFC);
      rd(8'h14, 32'h0000_0103, 2'h0);
      conv(18'h1_FFFC);
      conv(18'h1_FFFB);
      chk("pin", 32'(pin), 32'h0000_0000);
      rd(8'h14, 32'h0000_0002, 2'h0);
      rd(8'h14, 32'h0000_0000, 2'h0);
   endtask

   task t_low;
      wr(8'h0C, 32'h0000_1000, 2'h0);
      conv(18'h0_1000);
      rd(8'h14, 32'h0000_0000, 2'h0);
      conv(18'h0_0FFF);
      rd(8'h14, 32'h0000_010C, 2'h0);
      conv(18'h0_1004);
      rd(8'h14, 32'h0000_010C, 2'h0);
      conv(18'h0_1005);
      rd(8'h14, 32'h0000_0000, 2'h0);
   endtask

   task t_supply;
      @(posedge aclk);
      sup_over <= 1'h1;
      repeat (2) @(posedge aclk);
      conv(18'h0_2000);
      rd(8'h14, 32'h0000_0130, 2'h0);
      wr(8'h04, 32'h0000_0002, 2'h0);
      conv(18'h0_2000);
      rd(8'h14, 32'h0000_0000, 2'h0);
      wr(8'h04, 32'h0000_0001, 2'h0);
      sup_over <= 1'h0;
      sup_under <= 1'h1;
      repeat (2) @(posedge aclk);
      conv(18'h3_0000);
      rd(8'h14, 32'h0000_01C0, 2'h0);
      sup_under <= 1'h0;
      repeat (6) @(posedge aclk);
      rd(8'h14, 32'h0000_0140, 2'h0);
      wr(8'h04, 32'h0000_0000, 2'h0);
      conv(18'h0_2000);
      rd(8'h14, 32'h0000_0000, 2'h0);
   endtask

   task t_frame;
      wr(8'h18, 32'h0000_0003, 2'h0);
      sup_over <= 1'h1;
      repeat (2) @(posedge aclk);
      conv(18'h0_2000);
      chk("append_bits", 32'(app_bits), 32'h0000_000C);
      chk("append_select", 32'(app_sel), 32'h0000_0003);
      host.open_frame(8);
      chk("frame_flags", 32'(frm), 32'h0000_0030);
      host.serve_alarm(got);
      chk("alarm seen", 32'(got), 32'h0000_0001);
      sup_over <= 1'h0;
      repeat (6) @(posedge aclk);
      chk("append_bits", 32'(app_bits), 32'h0000_0008);
      conv(18'h0_2000);
      chk("append_bits", 32'(app_bits), 32'h0000_0000);
   endtask

   task t_pinsel;
      wr(8'h00, 32'h0000_0000, 2'h0);
      repeat (3) @(posedge aclk);
      chk("pin", 32'(pin), 32'h0000_0001);
      alt_data <= 1'h0;
      repeat (3) @(posedge aclk);
      chk("pin", 32'(pin), 32'h0000_0000);
   endtask

   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'h1;
      t_reset;
      t_high;
      t_low;
      t_supply;
      t_frame;
      t_pinsel;
      tally_and_finish;
   end
endmodule

bind aatl_top aatl_monitor mon (
   .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .conv_done(conv_done), .conv_code(conv_code),
   .conversion_data(conversion_data), .convert_chip_select_n(convert_chip_select_n),
   .serial_flag_read(serial_flag_read), .frame_flags(frame_flags), .append_bits(append_bits),
   .append_select(append_select));
